// *** pkg/wdtl_pkg.sv ***
/*
 * Constants of the locked watchdog timer: special function addresses, control
 * field positions, reset values, prescaler codes, nonvolatile byte layout.
 * Assumes a byte-wide special function bus driven by the processor core.
 */
// Overview of operation
// - Prescaler code 1000 gives an immediate automatic reset, no timed period.
// - Prescaler code 1001 gives an immediate serial download reset request.
// - Response bit 3 clear: timeout issues a system reset.
// - Response bit 3 set: timeout raises the watchdog interrupt instead.
// - Every timeout sets the status flag in bit 2.
// - Status flag clears only by software zero or hardware reset.
// - Enable bit 1 defaults one; each setting clears the counter.
// - Control write lands only right after the write-enable bit is set.
// - Control register at 0xC0, bit addresses 0xC0 to 0xC7.
// - Lock bit is bit 7 of nonvolatile byte 0x3FFA, erased one.
// - Lock zero ignores enable and response writes, forcing one and zero.
// - Prescaler bits stay writable while locked.
// - Lock zero makes the default protection key 0x7F, not 0xFF.
// - Protection commits to 0x3FFF..0x3FFB only when key byte matches.
// - Counter counts crystal ticks; timeout is 2^code times 512 ticks.
// - After reset enabled, two-second timeout, response is system reset.
// - Watchdog interrupt is high priority, not gated by global enable.
package wdtl_pkg;
	localparam logic [7:0]  CTRL_ADDR    = 8'hC0;
	localparam logic [7:0]  KEY_ADDR     = 8'hBB;
	localparam logic [15:0] NV_ADDR      = 16'h3FFA;
	localparam logic [15:0] PROT_HI_ADDR = 16'h3FFF;
	localparam logic [15:0] PROT_LO_ADDR = 16'h3FFB;
	localparam int          PRE_LSB      = 4;
	localparam int          RESP_BIT     = 3;
	localparam int          STAT_BIT     = 2;
	localparam int          EN_BIT       = 1;
	localparam int          UNLOCK_BIT   = 0;
	localparam int          LOCK_BIT     = 7;
	localparam logic [3:0]  PRE_RST      = 4'h7;
	localparam logic [3:0]  PRE_AUTO     = 4'h8;
	localparam logic [3:0]  PRE_SDL      = 4'h9;
	localparam logic [7:0]  KEY_LOCKED   = 8'h7F;
	localparam logic [7:0]  KEY_OPEN     = 8'hFF;
	localparam logic [7:0]  NV_ERASED    = 8'hFF;
	localparam int          BASE_LOG2    = 9;
	localparam int          CNT_W        = 16;
	localparam real         XTAL_HZ      = 32768.0;
	localparam real         CLK_HZ       = 100.0e6;
	// Clock cycles per crystal period, rounded to nearest, for reference of the sampler
	localparam int          XTAL_CYC     = int'(CLK_HZ / XTAL_HZ);
	typedef enum logic [1:0] {
		WDTL_IDLE   = 2'b00,
		WDTL_UNLOCK = 2'b01,
		WDTL_ARMED  = 2'b10
	} wdtl_wr_e;
endpackage : wdtl_pkg

// *** core/wdtl_core.sv ***
/*
 * Watchdog timer with nonvolatile lock, seen by the core as one bit-addressable
 * control register plus the flash key register.
 * Assumes: sfr strobes are single-cycle pulses on clk_i, instr_end_i pulses at
 * the last cycle of each instruction, crystal_input_i is asynchronous, and the
 * nonvolatile byte is a stable level on clk_i.
 */
`timescale 1ns/1ps
module wdtl_core (
	// Clock and resets
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        sys_reset_i,
	// Special function bus
	input  wire logic [7:0]  sfr_addr_i,
	input  wire logic        sfr_wr_i,
	input  wire logic [7:0]  sfr_wdata_i,
	input  wire logic        sfr_bit_wr_i,
	input  wire logic [7:0]  sfr_bit_addr_i,
	input  wire logic        sfr_bit_val_i,
	input  wire logic        sfr_rd_i,
	input  wire logic        instr_end_i,
	output logic      [7:0]  sfr_rdata_o,
	// Crystal and nonvolatile byte
	input  wire logic        crystal_input_i,
	input  wire logic [7:0]  nv_lock_key_byte_i,
	input  wire logic        prot_req_i,
	// Responses
	output logic             wdt_reset_o,
	output logic             wdt_irq_o,
	output logic             wdt_irq_high_prio_o,
	output logic             serial_download_o,
	output logic             prot_commit_o,
	output logic             prot_reject_o,
	output logic      [7:0]  default_key_o
);

	// ==========================================================
	// Decode
	logic [3:0]                 pre_r;
	logic                       resp_r;
	logic                       stat_r;
	logic                       en_r;
	logic [7:0]                 key_r;
	logic [wdtl_pkg::CNT_W-1:0] cnt_r;
	wdtl_pkg::wdtl_wr_e         wr_st_r;
	logic                       locked;
	logic                       ctrl_hit;
	logic [7:0]                 wr_mask;
	logic [7:0]                 wr_val;
	logic                       apply;
	logic                       unlock_req;
	logic                       timeout;
	logic                       instant;
	logic                       xtal_tick;

	function automatic logic [7:0] onehot3(input logic [2:0] idx);
		onehot3 = 8'h01 << idx;
	endfunction : onehot3

	function automatic logic [7:0] ctrl_view(input logic [3:0] p, input logic r,
		input logic s, input logic e, input logic u);
		ctrl_view = {p, r, s, e, u};
	endfunction : ctrl_view

	assign locked = ~nv_lock_key_byte_i[wdtl_pkg::LOCK_BIT];

	// Byte or single-bit write, both folded into mask and value
	always_comb begin
		ctrl_hit = 1'b0;
		wr_mask  = 8'h00;
		wr_val   = 8'h00;
		if (sfr_wr_i && sfr_addr_i == wdtl_pkg::CTRL_ADDR) begin
			ctrl_hit = 1'b1;
			wr_mask  = 8'hFF;
			wr_val   = sfr_wdata_i;
		end else if (sfr_bit_wr_i && sfr_bit_addr_i[7:3] == wdtl_pkg::CTRL_ADDR[7:3]) begin
			ctrl_hit = 1'b1;
			wr_mask  = onehot3(sfr_bit_addr_i[2:0]);
			wr_val   = sfr_bit_val_i ? wr_mask : 8'h00;
		end
	end

	assign apply      = ctrl_hit && wr_st_r == wdtl_pkg::WDTL_ARMED;
	assign unlock_req = ctrl_hit && !apply && wr_mask[wdtl_pkg::UNLOCK_BIT]
		&& wr_val[wdtl_pkg::UNLOCK_BIT];

	// ==========================================================
	// Unlock sequencer
	always_ff @(posedge clk_i) begin
		if (reset_i || sys_reset_i) begin
			wr_st_r <= wdtl_pkg::WDTL_IDLE;
		end else begin
			unique case (wr_st_r)
				wdtl_pkg::WDTL_IDLE: begin
					if (unlock_req) begin
						wr_st_r <= instr_end_i ? wdtl_pkg::WDTL_ARMED : wdtl_pkg::WDTL_UNLOCK;
					end
				end
				wdtl_pkg::WDTL_UNLOCK: begin
					if (instr_end_i) begin
						wr_st_r <= wdtl_pkg::WDTL_ARMED;
					end
				end
				wdtl_pkg::WDTL_ARMED: begin
					if (apply || instr_end_i) begin
						wr_st_r <= wdtl_pkg::WDTL_IDLE;
					end
				end
				default: begin
					wr_st_r <= wdtl_pkg::WDTL_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Control fields
	always_ff @(posedge clk_i) begin
		if (reset_i || sys_reset_i) begin
			pre_r <= wdtl_pkg::PRE_RST;
		end else if (apply) begin
			for (int i = 0; i < 4; i++) begin
				if (wr_mask[wdtl_pkg::PRE_LSB+i]) begin
					pre_r[i] <= wr_val[wdtl_pkg::PRE_LSB+i];
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || sys_reset_i) begin
			resp_r <= 1'b0;
		end else if (locked) begin
			resp_r <= 1'b0;
		end else if (apply && wr_mask[wdtl_pkg::RESP_BIT]) begin
			resp_r <= wr_val[wdtl_pkg::RESP_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || sys_reset_i) begin
			en_r <= 1'b1;
		end else if (locked) begin
			en_r <= 1'b1;
		end else if (apply && wr_mask[wdtl_pkg::EN_BIT]) begin
			en_r <= wr_val[wdtl_pkg::EN_BIT];
		end
	end

	// Only the external reset or a software zero clears it; a watchdog-driven reset does not
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			stat_r <= 1'b0;
		end else if (timeout || instant) begin
			stat_r <= 1'b1;
		end else if (apply && wr_mask[wdtl_pkg::STAT_BIT] && !wr_val[wdtl_pkg::STAT_BIT]) begin
			stat_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || sys_reset_i) begin
			key_r <= wdtl_pkg::KEY_OPEN;
		end else if (sfr_wr_i && sfr_addr_i == wdtl_pkg::KEY_ADDR) begin
			key_r <= sfr_wdata_i;
		end
	end

	// ==========================================================
	// Crystal sampling and counter
	logic xtal_s1_r;
	logic xtal_s2_r;
	logic xtal_d_r;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			xtal_s1_r <= 1'b0;
			xtal_s2_r <= 1'b0;
			xtal_d_r  <= 1'b0;
		end else begin
			xtal_s1_r <= crystal_input_i;
			xtal_s2_r <= xtal_s1_r;
			xtal_d_r  <= xtal_s2_r;
		end
	end

	assign xtal_tick = xtal_s2_r && !xtal_d_r;

	// Last count before expiry is 2^(code+9)-1, one bit wider for code 7
	logic [wdtl_pkg::CNT_W:0] limit;
	assign limit   = (17'h00001 << (5'(pre_r[2:0]) + 5'(wdtl_pkg::BASE_LOG2))) - 17'h00001;
	assign timeout = en_r && !pre_r[3] && xtal_tick && {1'b0, cnt_r} == limit;
	assign instant = en_r && (pre_r == wdtl_pkg::PRE_AUTO || pre_r == wdtl_pkg::PRE_SDL);

	always_ff @(posedge clk_i) begin
		if (reset_i || sys_reset_i) begin
			cnt_r <= '0;
		end else if (apply && wr_mask[wdtl_pkg::EN_BIT] && wr_val[wdtl_pkg::EN_BIT]) begin
			cnt_r <= '0;
		end else if (!en_r || timeout || instant) begin
			cnt_r <= '0;
		end else if (xtal_tick) begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end

	// ==========================================================
	// Responses
	always_ff @(posedge clk_i) begin
		if (reset_i || sys_reset_i) begin
			wdt_reset_o       <= 1'b0;
			wdt_irq_o         <= 1'b0;
			serial_download_o <= 1'b0;
		end else begin
			wdt_reset_o       <= (timeout && !resp_r)
				|| (instant && pre_r == wdtl_pkg::PRE_AUTO);
			wdt_irq_o         <= timeout && resp_r;
			serial_download_o <= instant && pre_r == wdtl_pkg::PRE_SDL;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wdt_irq_high_prio_o <= 1'b0;
		end else begin
			wdt_irq_high_prio_o <= 1'b1;
		end
	end

	// ==========================================================
	// Flash key and protection commit
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			prot_commit_o <= 1'b0;
			prot_reject_o <= 1'b0;
			default_key_o <= wdtl_pkg::KEY_OPEN;
		end else begin
			prot_commit_o <= prot_req_i && nv_lock_key_byte_i == key_r;
			prot_reject_o <= prot_req_i && nv_lock_key_byte_i != key_r;
			default_key_o <= locked ? wdtl_pkg::KEY_LOCKED : wdtl_pkg::KEY_OPEN;
		end
	end

	// ==========================================================
	// Read port
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sfr_rdata_o <= 8'h00;
		end else if (sfr_rd_i) begin
			if (sfr_addr_i == wdtl_pkg::CTRL_ADDR) begin
				sfr_rdata_o <= ctrl_view(pre_r, resp_r, stat_r, en_r,
					wr_st_r != wdtl_pkg::WDTL_IDLE);
			end else if (sfr_addr_i == wdtl_pkg::KEY_ADDR) begin
				sfr_rdata_o <= key_r;
			end else begin
				sfr_rdata_o <= 8'h00;
			end
		end
	end

endmodule : wdtl_core

// *** tb/wdtl_chk.sv ***
/*
 * Port checker of the locked watchdog core.
 * Assumes one clock domain and a bind onto wdtl_core.
 */
`timescale 1ns/1ps
module wdtl_chk (
	// Watched ports
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       sys_reset_i,
	input  wire logic       sfr_rd_i,
	input  wire logic [7:0] sfr_rdata_o,
	input  wire logic [7:0] nv_lock_key_byte_i,
	input  wire logic       prot_req_i,
	input  wire logic       wdt_reset_o,
	input  wire logic       wdt_irq_o,
	input  wire logic       wdt_irq_high_prio_o,
	input  wire logic       prot_commit_o,
	input  wire logic       prot_reject_o,
	input  wire logic [7:0] default_key_o
);
	// ====================
	// Properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_prio_held_high:
		assert property (!$past(reset_i) && !$past(sys_reset_i) |-> wdt_irq_high_prio_o)
		else $error("priority dropped");
	a_key_follows_lock:
		assert property ($stable(nv_lock_key_byte_i) && !$past(reset_i) |-> default_key_o
			== (nv_lock_key_byte_i[7] ? wdtl_pkg::KEY_OPEN : wdtl_pkg::KEY_LOCKED))
		else $error("default key wrong");
	a_reset_quiet:
		assert property ($fell(reset_i) |-> default_key_o == wdtl_pkg::KEY_OPEN
			&& !wdt_irq_high_prio_o && !wdt_reset_o && !wdt_irq_o)
		else $error("outputs not cleared");
	a_prot_answers:
		assert property ($past(prot_req_i) |-> prot_commit_o != prot_reject_o)
		else $error("no single answer");
	a_prot_caused:
		assert property (prot_commit_o || prot_reject_o |-> $past(prot_req_i))
		else $error("answer without request");
	a_irq_spacing:
		assert property (wdt_irq_o |=> !wdt_irq_o [*8])
		else $error("interrupt repeats");
	a_one_response:
		assert property (!(wdt_reset_o && wdt_irq_o))
		else $error("reset and interrupt");
	a_rdata_holds:
		assert property (!$past(sfr_rd_i) && !$past(reset_i) |-> $stable(sfr_rdata_o))
		else $error("read data moved");
	c_irq: cover property (wdt_irq_o);
	c_reset: cover property (wdt_reset_o);
	c_commit: cover property (prot_commit_o);
endmodule : wdtl_chk

// *** tb/wdtl_core_tb.sv ***
/*
 * Self-checking bench of the locked watchdog core.
 * Assumes nothing outside: bus, crystal and nonvolatile byte are driven here.
 */
`timescale 1ns/1ps
module wdtl_core_tb;
	localparam logic [7:0] CA = wdtl_pkg::CTRL_ADDR;
	localparam time        TK = 82;
	logic       clk_i = '0, reset_i = '1, sys_reset_i = '0, crystal_input_i = '0;
	logic       sfr_wr_i = '0, sfr_bit_wr_i = '0, sfr_bit_val_i = '0, sfr_rd_i = '0;
	logic       instr_end_i = '0, prot_req_i = '0;
	logic [7:0] sfr_addr_i = '0, sfr_wdata_i = '0, sfr_bit_addr_i = '0;
	logic [7:0] nv_lock_key_byte_i = 8'hFF;
	logic [7:0] sfr_rdata_o, default_key_o, key_v, rd_v;
	logic       wdt_reset_o, wdt_irq_o, wdt_irq_high_prio_o;
	logic       serial_download_o, prot_commit_o, prot_reject_o;
	int         miscompares = 0, check_count = 0, cyc = 0, e_ok = 0;
	int         n_rst = 0, n_irq = 0, n_ok = 0, n_bad = 0;
	time        t0, t_p;
	wdtl_core dut (.*);
	initial forever #5 clk_i = ~clk_i;
	always #41 crystal_input_i = ~crystal_input_i;
	// ====================
	// Pulse monitor
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		n_rst <= n_rst + int'(wdt_reset_o === 1'b1);
		n_irq <= n_irq + int'(wdt_irq_o === 1'b1);
		n_ok <= n_ok + int'(prot_commit_o === 1'b1);
		n_bad <= n_bad + int'(prot_reject_o === 1'b1);
		if (wdt_reset_o === 1'b1 || wdt_irq_o === 1'b1) t_p <= $time;
		if (cyc == 40000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	// ====================
	// Tasks
	task automatic step();
		@(posedge clk_i);
		#1;
	endtask : step
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic timeout();
		int tot;
		tot = n_rst + n_irq;
		for (int i = 0; i < 6000 && n_rst + n_irq == tot; i++) step();
		check_count++;
		if (t_p - t0 < 511 * TK || t_p - t0 > 514 * TK) begin
			miscompares++;
			$display("CHECK FAILED at %0t: timeout took %0t", $time, t_p - t0);
		end
	endtask : timeout
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr_i = a;
		sfr_wdata_i = d;
		sfr_wr_i = 1'b1;
		step();
		sfr_wr_i = 1'b0;
	endtask : wr
	// Unlock through bit 0xC0, optionally one idle instruction, then write
	task automatic ctl(input logic [7:0] d, input logic idle);
		sfr_bit_addr_i = CA;
		sfr_bit_val_i = 1'b1;
		sfr_bit_wr_i = 1'b1;
		step();
		sfr_bit_wr_i = 1'b0;
		if (idle) step();
		wr(CA, d);
	endtask : ctl
	task automatic rd(input logic [7:0] a);
		sfr_addr_i = a;
		sfr_rd_i = 1'b1;
		step();
		sfr_rd_i = 1'b0;
		step();
		rd_v = sfr_rdata_o;
	endtask : rd
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	// ====================
	// Scenarios
	initial begin
		key_v = 8'($urandom(15));
		repeat (5) step();
		reset_i = 1'b0;
		instr_end_i = 1'b1;
		rd(CA);
		chk(rd_v, 8'h72);
		chk(default_key_o, wdtl_pkg::KEY_OPEN);
		chk({7'h00, wdt_irq_high_prio_o}, 8'h01);
		wr(CA, 8'h00);
		rd(CA);
		chk(rd_v, 8'h72);
		ctl(8'h00, 1'b1);
		rd(CA);
		chk(rd_v, 8'h72);
		ctl(8'h0A, 1'b0);
		t0 = $time;
		timeout();
		rd(CA);
		chk(rd_v, 8'h0E);
		chk(8'(n_rst), 8'h00);
		sys_reset_i = 1'b1;
		step();
		sys_reset_i = 1'b0;
		rd(CA);
		chk(rd_v, 8'h76);
		ctl(8'h02, 1'b0);
		t0 = $time;
		rd(CA);
		chk(rd_v, 8'h02);
		timeout();
		chk(8'(n_rst), 8'h01);
		chk(8'(n_irq), 8'h01);
		ctl(8'h82, 1'b0);
		repeat (3) step();
		chk({7'h00, wdt_reset_o}, 8'h01);
		ctl(8'h92, 1'b0);
		repeat (3) step();
		chk({6'h00, serial_download_o, wdt_reset_o}, 8'h02);
		nv_lock_key_byte_i = {1'b0, 7'($urandom())};
		repeat (3) step();
		chk(default_key_o, wdtl_pkg::KEY_LOCKED);
		for (int i = 0; i < 3; i++) begin
			key_v = {4'($urandom() % 8), 4'h8};
			ctl(key_v, 1'b0);
			rd(CA);
			chk(rd_v & 8'hFB, {key_v[7:4], 4'h2});
		end
		for (int i = 0; i < 4; i++) begin
			key_v = i[0] ? nv_lock_key_byte_i : 8'($urandom());
			e_ok += int'(key_v == nv_lock_key_byte_i);
			wr(wdtl_pkg::KEY_ADDR, key_v);
			prot_req_i = 1'b1;
			step();
			prot_req_i = 1'b0;
			step();
		end
		step();
		chk(8'(n_ok), 8'(e_ok));
		chk(8'(n_bad), 8'(4 - e_ok));
		tally_and_finish();
	end
endmodule : wdtl_core_tb
bind wdtl_core wdtl_chk u_chk (.*);
